// file: include/iar_pkg.sv
// package for the i2c address and interrupt register slice
// assumes a plain register port with 16-bit address registers and byte-wide other registers at word indices
`default_nettype none
package iar_pkg;
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFS_OWN_ADDRESS = 4'h0;
  localparam logic [3:0] OFS_TARGET_ADDRESS = 4'h1;
  localparam logic [3:0] OFS_EVENT_INT_ENABLE = 4'h2;
  localparam logic [3:0] OFS_SHARED_INT_ENABLE = 4'h3;
  localparam logic [3:0] OFS_SHARED_INT_FLAG = 4'h4;
  localparam logic [3:0] OFS_UNIT1_INT_ENABLE = 4'h5;
  localparam logic [3:0] OFS_UNIT1_INT_FLAG = 4'h6;
  localparam logic [3:0] OFS_INST0_TX_BUFFER = 4'h7;
  localparam logic [3:0] OFS_INST0_RX_BUFFER = 4'h8;
  localparam logic [3:0] OFS_INST1_TX_BUFFER = 4'h9;
  localparam logic [3:0] OFS_INST1_RX_BUFFER = 4'hA;
  localparam logic [3:0] OFS_MATCH_STATUS = 4'hB;
  // field positions
  localparam int GCEN_BIT = 15;
  localparam int ADDR_MSB = 9;
  localparam int ADDR7_MSB = 6;
  localparam int TX_BIT = 3;
  localparam int RX_BIT = 2;
  // owned and writable masks
  localparam logic [15:0] OWN_ADDR_MASK = 16'h83FF;
  localparam logic [15:0] TGT_ADDR_MASK = 16'h03FF;
  localparam logic [7:0] EVT_IE_MASK = 8'h0F;
  localparam logic [7:0] UNIT_BITS_MASK = 8'h0C;
  // reset values
  localparam logic [15:0] RST_OWN_ADDRESS = 16'h0000;
  localparam logic [15:0] RST_TARGET_ADDRESS = 16'h0000;
  localparam logic [7:0] RST_EVENT_IE = 8'h00;
  localparam logic [7:0] RST_SHARED = 8'h00;
  localparam logic [7:0] RST_FLAGS = 8'h08;
  localparam logic [9:0] GEN_CALL_ADDR = 10'h000;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } iar_bus_s;

  typedef struct packed {
    logic nack;
    logic stop;
    logic start;
    logic arb_lost;
  } iar_events_s;
endpackage
`default_nettype wire

// file: src/iar_regs.sv
// register slice of an i2c unit: own/target address, event enables, shared flags
// assumes the i2c engine supplies events and data strobes on the same clock
`default_nettype none

// How it works
// - general call answered only when enable set
// - own address right-justified, 7-bit ignores 9-7
// - 10-bit mode matches all ten bits
// - target address used only as master
// - target address right-justified, same alignment rules
// - event enables bits 3-0, 7-4 reserved
// - foreign shared bits 7-4, 1-0 untouched
// - instance 0 enable bit 3 transmit
// - instance 0 enable bit 2 receive
// - instance 0 tx flag set when empty
// - instance 0 rx flag set on character
// - instance 1 enable bit 3 transmit
// - instance 1 enable bit 2 receive
// - instance 1 tx flag set when empty
// - instance 1 rx flag set on character
// - general call enable at bit 15
// - rx buffer read clears rx flag
// - tx buffer write clears tx flag
module iar_regs (
  input wire logic clock,
  input wire logic rst_b,
  input wire iar_pkg::iar_bus_s bus,
  output logic [15:0] rdata,
  input wire logic mode_10bit_own,
  input wire logic mode_10bit_target,
  input wire logic is_master,
  input wire logic [9:0] rx_address,
  input wire logic rx_address_valid,
  output logic own_match,
  output logic gen_call_match,
  output logic [9:0] target_address_out,
  output logic target_10bit_out,
  input wire iar_pkg::iar_events_s events,
  output logic event_irq,
  input wire logic [1:0] tx_empty_set,
  input wire logic [1:0] rx_char_set,
  input wire logic [7:0] rx_char0,
  input wire logic [7:0] rx_char1,
  output logic [7:0] tx_data0,
  output logic [7:0] tx_data1,
  output logic [1:0] tx_load,
  output logic [1:0] tx_irq,
  output logic [1:0] rx_irq,
  input wire logic [7:0] foreign_ie_in,
  input wire logic [7:0] foreign_ifg_in
);

  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic [15:0] i2c_own_address;
  logic [15:0] i2c_target_address;
  logic [7:0] i2c_event_int_enable;
  logic [7:0] shared_int_enable_2;
  logic [7:0] shared_int_flag_2;
  logic [7:0] second_unit_int_enable;
  logic [7:0] second_unit_int_flag;
  logic [7:0] inst0_rx_buffer;
  logic [7:0] inst1_rx_buffer;
  logic [1:0] match_status;
  logic wr_own, wr_tgt, wr_eie, wr_sie, wr_sif, wr_uie, wr_uif, wr_tx0, wr_tx1, rd_rx0, rd_rx1;
  logic [9:0] own_cmp, rx_cmp, tgt_field;
  logic general_call_enable;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  always_comb begin
    wr_own = 1'b0;
    wr_tgt = 1'b0;
    wr_eie = 1'b0;
    wr_sie = 1'b0;
    wr_sif = 1'b0;
    wr_uie = 1'b0;
    wr_uif = 1'b0;
    wr_tx0 = 1'b0;
    wr_tx1 = 1'b0;
    rd_rx0 = 1'b0;
    rd_rx1 = 1'b0;
    if (bus.addr == iar_pkg::OFS_OWN_ADDRESS) begin
      wr_own = bus.wr;
    end else if (bus.addr == iar_pkg::OFS_TARGET_ADDRESS) begin
      wr_tgt = bus.wr;
    end else if (bus.addr == iar_pkg::OFS_EVENT_INT_ENABLE) begin
      wr_eie = bus.wr;
    end else if (bus.addr == iar_pkg::OFS_SHARED_INT_ENABLE) begin
      wr_sie = bus.wr;
    end else if (bus.addr == iar_pkg::OFS_SHARED_INT_FLAG) begin
      wr_sif = bus.wr;
    end else if (bus.addr == iar_pkg::OFS_UNIT1_INT_ENABLE) begin
      wr_uie = bus.wr;
    end else if (bus.addr == iar_pkg::OFS_UNIT1_INT_FLAG) begin
      wr_uif = bus.wr;
    end else if (bus.addr == iar_pkg::OFS_INST0_TX_BUFFER) begin
      wr_tx0 = bus.wr;
    end else if (bus.addr == iar_pkg::OFS_INST0_RX_BUFFER) begin
      rd_rx0 = bus.rd;
    end else if (bus.addr == iar_pkg::OFS_INST1_TX_BUFFER) begin
      wr_tx1 = bus.wr;
    end else if (bus.addr == iar_pkg::OFS_INST1_RX_BUFFER) begin
      rd_rx1 = bus.rd;
    end
  end

  // ----------------------------------------
  // address registers
  // ----------------------------------------
  // reserved bits 14-10 stay zero
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      i2c_own_address <= iar_pkg::RST_OWN_ADDRESS;
    end else if (wr_own) begin
      i2c_own_address <= bus.wdata & iar_pkg::OWN_ADDR_MASK;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      i2c_target_address <= iar_pkg::RST_TARGET_ADDRESS;
    end else if (wr_tgt) begin
      i2c_target_address <= bus.wdata & iar_pkg::TGT_ADDR_MASK;
    end
  end

  // event enables, reserved upper nibble kept
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      i2c_event_int_enable <= iar_pkg::RST_EVENT_IE;
    end else if (wr_eie) begin
      i2c_event_int_enable <= (bus.wdata[7:0] & iar_pkg::EVT_IE_MASK)
        | (i2c_event_int_enable & ~iar_pkg::EVT_IE_MASK);
    end
  end

  // ----------------------------------------
  // shared enables: only bits 3-2 are ours
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      shared_int_enable_2 <= iar_pkg::RST_SHARED;
    end else if (wr_sie) begin
      shared_int_enable_2 <= bus.wdata[7:0] & iar_pkg::UNIT_BITS_MASK;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      second_unit_int_enable <= iar_pkg::RST_SHARED;
    end else if (wr_uie) begin
      second_unit_int_enable <= bus.wdata[7:0] & iar_pkg::UNIT_BITS_MASK;
    end
  end

  // ----------------------------------------
  // flags: hardware set beats any clear
  // ----------------------------------------
  // a clear landing with a set loses, so no buffer event is ever dropped
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      shared_int_flag_2 <= iar_pkg::RST_FLAGS;
    end else begin
      if (tx_empty_set[0]) begin
        shared_int_flag_2[iar_pkg::TX_BIT] <= 1'b1;
      end else if (wr_tx0) begin
        shared_int_flag_2[iar_pkg::TX_BIT] <= 1'b0;
      end else if (wr_sif) begin
        shared_int_flag_2[iar_pkg::TX_BIT] <= bus.wdata[iar_pkg::TX_BIT];
      end
      if (rx_char_set[0]) begin
        shared_int_flag_2[iar_pkg::RX_BIT] <= 1'b1;
      end else if (rd_rx0) begin
        shared_int_flag_2[iar_pkg::RX_BIT] <= 1'b0;
      end else if (wr_sif) begin
        shared_int_flag_2[iar_pkg::RX_BIT] <= bus.wdata[iar_pkg::RX_BIT];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      second_unit_int_flag <= iar_pkg::RST_FLAGS;
    end else begin
      if (tx_empty_set[1]) begin
        second_unit_int_flag[iar_pkg::TX_BIT] <= 1'b1;
      end else if (wr_tx1) begin
        second_unit_int_flag[iar_pkg::TX_BIT] <= 1'b0;
      end else if (wr_uif) begin
        second_unit_int_flag[iar_pkg::TX_BIT] <= bus.wdata[iar_pkg::TX_BIT];
      end
      if (rx_char_set[1]) begin
        second_unit_int_flag[iar_pkg::RX_BIT] <= 1'b1;
      end else if (rd_rx1) begin
        second_unit_int_flag[iar_pkg::RX_BIT] <= 1'b0;
      end else if (wr_uif) begin
        second_unit_int_flag[iar_pkg::RX_BIT] <= bus.wdata[iar_pkg::RX_BIT];
      end
    end
  end

  // ----------------------------------------
  // data buffers
  // ----------------------------------------
  // receive character capture, instance 0
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      inst0_rx_buffer <= 8'h00;
    end else if (rx_char_set[0]) begin
      inst0_rx_buffer <= rx_char0;
    end
  end

  // receive character capture, instance 1
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      inst1_rx_buffer <= 8'h00;
    end else if (rx_char_set[1]) begin
      inst1_rx_buffer <= rx_char1;
    end
  end

  // load pulse to the engine, one cycle after the buffer write
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tx_load <= 2'b00;
    end else begin
      tx_load <= {wr_tx1, wr_tx0};
    end
  end

  // transmit data held for the engine until the next buffer write
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tx_data0 <= 8'h00;
      tx_data1 <= 8'h00;
    end else begin
      if (wr_tx0) begin
        tx_data0 <= bus.wdata[7:0];
      end
      if (wr_tx1) begin
        tx_data1 <= bus.wdata[7:0];
      end
    end
  end

  // ----------------------------------------
  // address matching
  // ----------------------------------------
  assign general_call_enable = i2c_own_address[iar_pkg::GCEN_BIT];
  // 7-bit mode drops bits 9-7 on both sides
  always_comb begin
    if (mode_10bit_own) begin
      own_cmp = i2c_own_address[iar_pkg::ADDR_MSB:0];
      rx_cmp = rx_address;
    end else begin
      own_cmp = {3'b000, i2c_own_address[iar_pkg::ADDR7_MSB:0]};
      rx_cmp = {3'b000, rx_address[iar_pkg::ADDR7_MSB:0]};
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      own_match <= 1'b0;
      gen_call_match <= 1'b0;
    end else begin
      own_match <= rx_address_valid && (rx_cmp == own_cmp);
      gen_call_match <= rx_address_valid && general_call_enable
        && (rx_cmp == iar_pkg::GEN_CALL_ADDR);
    end
  end

  assign match_status = {gen_call_match, own_match};

  // target address presented only in master mode, right-justified
  always_comb begin
    if (mode_10bit_target) begin
      tgt_field = i2c_target_address[iar_pkg::ADDR_MSB:0];
    end else begin
      tgt_field = {3'b000, i2c_target_address[iar_pkg::ADDR7_MSB:0]};
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      target_address_out <= 10'h000;
      target_10bit_out <= 1'b0;
    end else begin
      target_address_out <= is_master ? tgt_field : 10'h000;
      target_10bit_out <= is_master & mode_10bit_target;
    end
  end

  // ----------------------------------------
  // requests
  // ----------------------------------------
  assign tx_irq[0] = shared_int_flag_2[iar_pkg::TX_BIT] & shared_int_enable_2[iar_pkg::TX_BIT];
  assign rx_irq[0] = shared_int_flag_2[iar_pkg::RX_BIT] & shared_int_enable_2[iar_pkg::RX_BIT];
  assign tx_irq[1] = second_unit_int_flag[iar_pkg::TX_BIT] & second_unit_int_enable[iar_pkg::TX_BIT];
  assign rx_irq[1] = second_unit_int_flag[iar_pkg::RX_BIT] & second_unit_int_enable[iar_pkg::RX_BIT];
  assign event_irq = |({events.nack, events.stop, events.start, events.arb_lost}
    & i2c_event_int_enable[3:0]);

  // ----------------------------------------
  // read data, one cycle after the strobe
  // ----------------------------------------
  // foreign bits come from the other modules' own logic
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 16'h0000;
    end else if (bus.rd) begin
      if (bus.addr == iar_pkg::OFS_OWN_ADDRESS) begin
        rdata <= i2c_own_address;
      end else if (bus.addr == iar_pkg::OFS_TARGET_ADDRESS) begin
        rdata <= i2c_target_address;
      end else if (bus.addr == iar_pkg::OFS_EVENT_INT_ENABLE) begin
        rdata <= {8'h00, i2c_event_int_enable};
      end else if (bus.addr == iar_pkg::OFS_SHARED_INT_ENABLE) begin
        rdata <= {8'h00, (foreign_ie_in & ~iar_pkg::UNIT_BITS_MASK) | shared_int_enable_2};
      end else if (bus.addr == iar_pkg::OFS_SHARED_INT_FLAG) begin
        rdata <= {8'h00, (foreign_ifg_in & ~iar_pkg::UNIT_BITS_MASK) | shared_int_flag_2};
      end else if (bus.addr == iar_pkg::OFS_UNIT1_INT_ENABLE) begin
        rdata <= {8'h00, second_unit_int_enable};
      end else if (bus.addr == iar_pkg::OFS_UNIT1_INT_FLAG) begin
        rdata <= {8'h00, second_unit_int_flag};
      end else if (bus.addr == iar_pkg::OFS_INST0_RX_BUFFER) begin
        rdata <= {8'h00, inst0_rx_buffer};
      end else if (bus.addr == iar_pkg::OFS_INST1_RX_BUFFER) begin
        rdata <= {8'h00, inst1_rx_buffer};
      end else if (bus.addr == iar_pkg::OFS_MATCH_STATUS) begin
        rdata <= {14'h0000, match_status};
      end else begin
        rdata <= 16'h0000;
      end
    end
  end

endmodule // iar_regs
`default_nettype wire

// file: testbench/iar_regs_sva.sv
// checker for the i2c address and interrupt register slice
// assumes it is bound onto iar_regs: one clock, async active-low reset
`default_nettype none
module iar_regs_sva (
  input wire logic clock,
  input wire logic rst_b,
  input wire iar_pkg::iar_bus_s bus,
  input wire logic [15:0] rdata,
  input wire logic is_master,
  input wire logic mode_10bit_target,
  input wire logic rx_address_valid,
  input wire logic own_match,
  input wire logic gen_call_match,
  input wire logic [9:0] target_address_out,
  input wire iar_pkg::iar_events_s events,
  input wire logic event_irq,
  input wire logic [1:0] tx_empty_set,
  input wire logic [1:0] rx_char_set,
  input wire logic [7:0] tx_data0,
  input wire logic [1:0] tx_load,
  input wire logic [1:0] tx_irq,
  input wire logic [1:0] rx_irq
);
  // --------------------------------
  // buffer access steps and register slice checks
  // --------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence tx0_write_s;
    bus.wr && bus.addr == iar_pkg::OFS_INST0_TX_BUFFER && !tx_empty_set[0];
  endsequence
  sequence rx0_read_s;
    bus.rd && bus.addr == iar_pkg::OFS_INST0_RX_BUFFER && !rx_char_set[0];
  endsequence
  tx_load_a: assert property (tx0_write_s |=> tx_load[0] && tx_data0 == $past(bus.wdata[7:0]))
    else $error("tx load missing after buffer write");
  tx_clear_a: assert property (tx0_write_s |=> !tx_irq[0])
    else $error("tx request stands after buffer write");
  rx_clear_a: assert property (rx0_read_s |=> !rx_irq[0])
    else $error("rx request stands after buffer read");
  load_cause_a: assert property (tx_load[0] |-> $past(bus.wr && bus.addr == iar_pkg::OFS_INST0_TX_BUFFER))
    else $error("tx load without buffer write");
  target_gate_a: assert property (!is_master |=> target_address_out == 10'h000)
    else $error("target address shown while not master");
  target_short_a: assert property (!mode_10bit_target |=> target_address_out[9:7] == 3'h0)
    else $error("target upper bits leak in 7-bit mode");
  match_cause_a: assert property ((own_match || gen_call_match) |-> $past(rx_address_valid))
    else $error("match pulse without heard address");
  event_gate_a: assert property (events == 4'h0 |-> !event_irq)
    else $error("event request without event");
  unmapped_a: assert property (bus.rd && bus.addr > iar_pkg::OFS_MATCH_STATUS |=> rdata == 16'h0000)
    else $error("unmapped read not zero");
endmodule // iar_regs_sva
bind iar_regs iar_regs_sva i_iar_regs_sva (.clock(clock), .rst_b(rst_b), .bus(bus), .rdata(rdata),
  .is_master(is_master), .mode_10bit_target(mode_10bit_target), .rx_address_valid(rx_address_valid),
  .own_match(own_match), .gen_call_match(gen_call_match), .target_address_out(target_address_out),
  .events(events), .event_irq(event_irq), .tx_empty_set(tx_empty_set), .rx_char_set(rx_char_set),
  .tx_data0(tx_data0), .tx_load(tx_load), .tx_irq(tx_irq), .rx_irq(rx_irq));
`default_nettype wire

// file: testbench/iar_bus_peer.sv
// model of another bus party sending an address beat to the unit
// assumes one request pulse from the bench per beat
`default_nettype none
module iar_bus_peer (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic req,
  input wire logic [9:0] req_address,
  output logic [9:0] rx_address,
  output logic rx_address_valid
);
  timeunit 1ns;
  timeprecision 100ps;
  // one-cycle beat; between beats the lines flip so nothing stale can match
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rx_address <= 10'h3FF;
      rx_address_valid <= 1'b0;
    end else begin
      rx_address <= req ? req_address : ~rx_address;
      rx_address_valid <= req;
    end
  end
endmodule // iar_bus_peer
`default_nettype wire

// file: testbench/iar_regs_tb_top.sv
// self-checking bench for the i2c address and interrupt register slice
// assumes iar_regs, iar_bus_peer and the bound checker are compiled first
`default_nettype none
module iar_regs_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  iar_pkg::iar_bus_s bus = '0;
  logic [15:0] rdata;
  logic mode_10bit_own = 1'b0;
  logic mode_10bit_target = 1'b0;
  logic is_master = 1'b0;
  logic [9:0] rx_address;
  logic rx_address_valid;
  logic own_match;
  logic gen_call_match;
  logic [9:0] target_address_out;
  logic target_10bit_out;
  iar_pkg::iar_events_s events = '0;
  logic event_irq;
  logic [1:0] tx_empty_set = 2'h0;
  logic [1:0] rx_char_set = 2'h0;
  logic [7:0] rx_char0 = 8'h00;
  logic [7:0] rx_char1 = 8'h00;
  logic [7:0] tx_data0;
  logic [7:0] tx_data1;
  logic [1:0] tx_load;
  logic [1:0] tx_irq;
  logic [1:0] rx_irq;
  logic [7:0] foreign_ie_in = 8'hA5;
  logic [7:0] foreign_ifg_in = 8'h5A;
  logic p_req = 1'b0;
  logic [9:0] p_addr = 10'h000;
  logic [31:0] seed = 32'h2D6AC6B3;
  int n_fail = 0;
  int checks_done = 0;

  always #2.5 clock = ~clock;

  iar_regs i_iar_regs (.clock(clock), .rst_b(rst_b), .bus(bus), .rdata(rdata), .mode_10bit_own(mode_10bit_own),
    .mode_10bit_target(mode_10bit_target), .is_master(is_master), .rx_address(rx_address),
    .rx_address_valid(rx_address_valid), .own_match(own_match), .gen_call_match(gen_call_match),
    .target_address_out(target_address_out), .target_10bit_out(target_10bit_out), .events(events),
    .event_irq(event_irq), .tx_empty_set(tx_empty_set), .rx_char_set(rx_char_set), .rx_char0(rx_char0),
    .rx_char1(rx_char1), .tx_data0(tx_data0), .tx_data1(tx_data1), .tx_load(tx_load), .tx_irq(tx_irq),
    .rx_irq(rx_irq), .foreign_ie_in(foreign_ie_in), .foreign_ifg_in(foreign_ifg_in));
  iar_bus_peer i_iar_bus_peer (.clock(clock), .rst_b(rst_b), .req(p_req), .req_address(p_addr),
    .rx_address(rx_address), .rx_address_valid(rx_address_valid));

  // ------------------------------
  // helpers
  // ------------------------------
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], ^(seed & 32'h80200003)};
    return seed;
  endfunction
  function automatic logic [15:0] shared_exp(input logic [7:0] foreign, input logic [1:0] own2);
    return {8'h00, (foreign & 8'hF3) | {4'h0, own2, 2'h0}};
  endfunction
  function automatic logic [9:0] tgt_exp(input logic [9:0] a, input logic m10, input logic master);
    return master ? (m10 ? a : {3'h0, a[6:0]}) : 10'h000;
  endfunction
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp, input string name);
    @(posedge clock);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus.rd <= 1'b0;
    #1 check(name, exp, rdata);
  endtask
  task automatic pulse(input logic [1:0] txs, input logic [1:0] rxs);
    @(posedge clock);
    tx_empty_set <= txs;
    rx_char_set <= rxs;
    @(posedge clock);
    tx_empty_set <= 2'h0;
    rx_char_set <= 2'h0;
    #1;
  endtask
  task automatic heard(input logic [9:0] a, input logic e_own, input logic e_gc);
    @(posedge clock);
    p_req <= 1'b1;
    p_addr <= a;
    @(posedge clock);
    p_req <= 1'b0;
    @(posedge clock);
    #1 check("match", {14'h0, e_own, e_gc}, {14'h0, own_match, gen_call_match});
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    print_verdict();
  end

  // main sequence
  initial begin
    logic [15:0] v;
    logic [7:0] c;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    rd(iar_pkg::OFS_OWN_ADDRESS, 16'h0000, "own rst");
    rd(iar_pkg::OFS_EVENT_INT_ENABLE, 16'h0000, "evt rst");
    rd(iar_pkg::OFS_SHARED_INT_FLAG, shared_exp(foreign_ifg_in, 2'b10), "ifg rst");
    rd(iar_pkg::OFS_UNIT1_INT_FLAG, 16'h0008, "u1 ifg rst");
    wr(iar_pkg::OFS_OWN_ADDRESS, 16'hFFFF);
    rd(iar_pkg::OFS_OWN_ADDRESS, 16'h83FF, "own mask");
    wr(iar_pkg::OFS_EVENT_INT_ENABLE, 16'h00FF);
    rd(iar_pkg::OFS_EVENT_INT_ENABLE, 16'h000F, "evt mask");
    wr(iar_pkg::OFS_SHARED_INT_ENABLE, 16'h00FF);
    rd(iar_pkg::OFS_SHARED_INT_ENABLE, shared_exp(foreign_ie_in, 2'b11), "ie mask");
    wr(iar_pkg::OFS_UNIT1_INT_ENABLE, 16'h00FF);
    rd(iar_pkg::OFS_UNIT1_INT_ENABLE, 16'h000C, "u1 ie mask");
    wr(4'hD, 16'hFFFF);
    rd(4'hD, 16'h0000, "unmapped");
    check("tx irq", 16'h0003, tx_irq);
    for (int i = 0; i < 2; i++) begin
      c = 8'(rnd());
      @(posedge clock);
      if (i == 0) rx_char0 <= c;
      else rx_char1 <= c;
      wr(i ? iar_pkg::OFS_INST1_TX_BUFFER : iar_pkg::OFS_INST0_TX_BUFFER, {8'h00, c});
      #1 check("tx load", 16'(2'b01 << i), tx_load);
      check("tx data", c, i ? tx_data1 : tx_data0);
      check("tx irq clr", 16'h0000, tx_irq[i]);
      pulse(2'b01 << i, 2'b01 << i);
      check("tx irq set", 16'h0001, tx_irq[i]);
      check("rx irq set", 16'h0001, rx_irq[i]);
      rd(i ? iar_pkg::OFS_INST1_RX_BUFFER : iar_pkg::OFS_INST0_RX_BUFFER, {8'h00, c}, "rx buf");
      check("rx irq clr", 16'h0000, rx_irq[i]);
    end
    wr(iar_pkg::OFS_SHARED_INT_ENABLE, 16'h0000);
    wr(iar_pkg::OFS_UNIT1_INT_ENABLE, 16'h0000);
    pulse(2'b00, 2'b11);
    check("irq masked", 16'h0000, {tx_irq, rx_irq});
    rd(iar_pkg::OFS_UNIT1_INT_FLAG, 16'h000C, "u1 flags");
    rd(iar_pkg::OFS_SHARED_INT_FLAG, shared_exp(foreign_ifg_in, 2'b11), "flags");
    wr(iar_pkg::OFS_SHARED_INT_FLAG, 16'h0000);
    rd(iar_pkg::OFS_SHARED_INT_FLAG, shared_exp(foreign_ifg_in, 2'b00), "flags clr");
    @(posedge clock);
    bus <= '{addr: iar_pkg::OFS_INST0_TX_BUFFER, wdata: 16'h0000, wr: 1'b1, rd: 1'b0};
    tx_empty_set <= 2'b01;
    @(posedge clock);
    bus.wr <= 1'b0;
    tx_empty_set <= 2'b00;
    rd(iar_pkg::OFS_SHARED_INT_FLAG, shared_exp(foreign_ifg_in, 2'b10), "set wins");
    for (int k = 0; k < 4; k++) begin
      wr(iar_pkg::OFS_EVENT_INT_ENABLE, 16'h0001 << k);
      for (int n = 0; n < 4; n++) begin
        @(posedge clock);
        events <= 4'(rnd());
        #1 check("event irq", 16'(|(4'(events) & (4'h1 << k))), event_irq);
      end
    end
    v = 16'(rnd()) | 16'h0001;
    wr(iar_pkg::OFS_OWN_ADDRESS, {6'h00, v[9:0]});
    heard({~v[9:7], v[6:0]}, 1'b1, 1'b0);
    heard({v[9:7], v[6:0] ^ 7'h01}, 1'b0, 1'b0);
    @(posedge clock);
    mode_10bit_own <= 1'b1;
    heard({~v[9:7], v[6:0]}, 1'b0, 1'b0);
    heard(v[9:0], 1'b1, 1'b0);
    heard(10'h000, 1'b0, 1'b0);
    wr(iar_pkg::OFS_OWN_ADDRESS, {6'h20, v[9:0]});
    heard(10'h000, 1'b0, 1'b1);
    @(posedge clock);
    mode_10bit_own <= 1'b0;
    heard(10'h280, 1'b0, 1'b1);
    for (int j = 0; j < 4; j++) begin
      @(posedge clock);
      is_master <= j[1];
      mode_10bit_target <= j[0];
      v = 16'(rnd());
      wr(iar_pkg::OFS_TARGET_ADDRESS, v);
      rd(iar_pkg::OFS_TARGET_ADDRESS, v & 16'h03FF, "target reg");
      check("target out", tgt_exp(v[9:0], j[0], j[1]), target_address_out);
      check("target 10bit", {15'h0000, j[0] & j[1]}, target_10bit_out);
    end
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    rd(iar_pkg::OFS_SHARED_INT_ENABLE, shared_exp(foreign_ie_in, 2'b00), "ie rst");
    check("irq rst", 16'h0000, {12'h000, tx_irq, rx_irq});
    check("target rst", 16'h0000, {6'h00, target_address_out});
    rd(iar_pkg::OFS_OWN_ADDRESS, 16'h0000, "own rst2");
    rd(iar_pkg::OFS_UNIT1_INT_FLAG, 16'h0008, "u1 ifg rst2");
    print_verdict();
  end
endmodule // iar_regs_tb_top
`default_nettype wire
